// *** src/tsu_pkg.sv ***
// tsu_pkg: register map, field positions and reset values of the touch sense unit
// assumes an 8-bit register port with 16-bit byte addresses
package tsu_pkg;

  // ----------------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------------
  localparam logic [15:0] TSU_ADDR_CTRL_STAT = 16'hA01B; // conversion_control_status
  localparam logic [15:0] TSU_ADDR_HDTY_LO   = 16'hA01C; // high_duty_count_low
  localparam logic [15:0] TSU_ADDR_HDTY_HI   = 16'hA01D; // high_duty_count_high
  localparam logic [15:0] TSU_ADDR_LDTY_LO   = 16'hA01E; // low_duty_count_low
  localparam logic [15:0] TSU_ADDR_LDTY_HI   = 16'hA01F; // low_duty_count_high
  localparam logic [15:0] TSU_ADDR_BASE_LO   = 16'hA028; // baseline_low
  localparam logic [15:0] TSU_ADDR_BASE_HI   = 16'hA029; // baseline_high
  localparam logic [15:0] TSU_ADDR_THD_LO    = 16'hA02A; // detect_threshold_low
  localparam logic [15:0] TSU_ADDR_THD_HI    = 16'hA02B; // detect_threshold_high
  localparam logic [15:0] TSU_ADDR_PULL      = 16'hA02C; // ref_node_pull_control
  localparam logic [15:0] TSU_ADDR_MODE      = 16'hA030; // mode_control (extra)

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int TSU_BIT_BUSY   = 0; // read: busy, write: start
  localparam int TSU_BIT_IRQF   = 1;
  localparam int TSU_BIT_LOW_FREQ_NOISE_FLAG   = 2;
  localparam int TSU_BIT_PSRD   = 3;
  localparam int TSU_BIT_ASTD   = 4;
  localparam int TSU_CAP_LSB    = 5;
  localparam int TSU_PULL_I_EN  = 7;
  localparam int TSU_PULL_R_EN  = 6;
  localparam int TSU_PULL_SEL_W = 4;
  localparam int TSU_MODE_AUTO  = 0;
  localparam int TSU_MODE_THDS  = 1;
  localparam int TSU_MODE_BINI  = 2;

  // ----------------------------------------------------------------------------
  // reset values and types
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  TSU_RST_BYTE = 8'h00;
  localparam logic [15:0] TSU_RST_WORD = 16'h0000;
  localparam logic [3:0]  TSU_PULL_OFF = 4'h0;

  typedef enum logic [2:0] {
    TSU_IDLE = 3'b001,
    TSU_CONV = 3'b010,
    TSU_EVAL = 3'b100
  } tsu_state_e;

endpackage

// *** src/tsu_pull_drive.sv ***
// tsu_pull_drive: turns the pull control fields into per-element switch enables
// assumes the analog front end switches one leg per enable bit
`timescale 1ns/10ps

module tsu_pull_drive
  import tsu_pkg::*;
(
  input  wire logic                      mclk,       // system clock
  input  wire logic                      reset,      // sync reset, active high
  input  wire logic                      cur_en,     // current path enable
  input  wire logic                      res_en,     // resistor path enable
  input  wire logic [TSU_PULL_SEL_W-1:0] pull_sel,   // per-leg selection
  output logic      [TSU_PULL_SEL_W-1:0] cur_leg_q,  // 8/4/2/1 uA legs, msb first
  output logic      [TSU_PULL_SEL_W-1:0] res_leg_q   // 5k/10k/20k/40k legs, msb first
);

  // ----------------------------------------------------------------------------
  // one enable per leg, registered so switches never glitch
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < TSU_PULL_SEL_W; g++) begin : g_leg
      always_ff @(posedge mclk) begin
        if (reset) begin
          cur_leg_q[g] <= 1'b0;
          res_leg_q[g] <= 1'b0;
        end else begin
          cur_leg_q[g] <= cur_en & pull_sel[g];
          res_leg_q[g] <= res_en & pull_sel[g];
        end
      end
    end
  endgenerate

endmodule

// *** src/tsu_regs.sv ***
// tsu_regs: control, result and compensation registers of the touch sense unit
// assumes the conversion front end reports counts with a one-cycle done pulse,
// and that its noise/done inputs arrive in the mclk domain already
`timescale 1ns/10ps

// Function
// - control/status resets to zero; read bit0 busy, write bit0 start
// - high duty count is read-only 16 bits in two bytes, resets zero
// - low duty count is read-only 16-bit result in two bytes
// - baseline is writable 16 bits, resets zero, also updated by hardware
// - threshold is writable 16 bits in two bytes, resets zero
// - pull control drives DC pull onto reference node per its fields
// - bit 7 enables the DC current source path
// - bit 6 enables the DC resistor path
// - with current path, select bits switch 8/4/2/1 uA sources
// - with resistor path, select bits switch 5k/10k/20k/40k resistors
// - normal mode: start launches conversion, interrupt once result is ready
// - threshold mode zero: threshold alone; one: threshold plus baseline
// - baseline init: first count after entering self-scan loads baseline
module tsu_regs
  import tsu_pkg::*;
(
  input  wire logic        mclk,              // system clock, 200 MHz
  input  wire logic        reset,             // sync reset, active high
  input  wire logic [15:0] reg_addr,          // register byte address
  input  wire logic [7:0]  reg_wdata,         // write data
  input  wire logic        reg_wr,            // write strobe
  input  wire logic        reg_rd,            // read strobe
  output logic      [7:0]  reg_rdata_q,       // read data, cycle after strobe
  input  wire logic        conv_done,         // front end result pulse
  input  wire logic [15:0] conv_high_count,   // high duty count from front end
  input  wire logic [15:0] conv_low_count,    // low duty count from front end
  input  wire logic        conv_noise,        // low-frequency noise seen, pulse
  input  wire logic        avg_update,        // moving average result valid
  input  wire logic [15:0] avg_baseline,      // moving average new baseline
  output logic             conv_start_q,      // start pulse to the front end
  output logic             conv_busy_q,       // conversion in progress
  output logic             auto_mode_q,       // self-scan mode active
  output logic             wakeup_q,          // self-scan wakeup pulse
  output logic             touch_irq_q,       // interrupt flag level
  output logic      [2:0]  ref_cap_select_q,  // reference cap select
  output logic             start_idle_delay_enable_q, // auto start delay enable
  output logic             pseudo_random_seq_enable_q, // pseudo random enable
  output logic      [3:0]  cur_leg_q,         // current source legs
  output logic      [3:0]  res_leg_q          // resistor legs
);

  // ----------------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  logic        wr_ctrl;
  logic        start_req;
  logic        irq_clr;
  logic        low_freq_noise_flag_clr;
  logic        low_freq_noise_flag_q;
  logic [15:0] high_duty_count_q;
  logic [15:0] low_duty_count_q;
  logic [15:0] baseline_value_q;
  logic [15:0] threshold_value_q;
  logic        dc_current_enable_q;
  logic        dc_resistor_enable_q;
  logic [3:0]  dc_pull_select_q;
  logic        threshold_mode_select_q;
  logic        baseline_init_select_q;
  logic        first_auto_q;
  logic [16:0] limit;
  logic        over_limit;
  tsu_state_e  state_q;

  assign wr_ctrl   = reg_wr && hit(reg_addr, TSU_ADDR_CTRL_STAT);
  assign start_req = wr_ctrl && reg_wdata[TSU_BIT_BUSY];
  assign irq_clr   = wr_ctrl && !reg_wdata[TSU_BIT_IRQF];
  assign low_freq_noise_flag_clr  = wr_ctrl && !reg_wdata[TSU_BIT_LOW_FREQ_NOISE_FLAG];

  // ----------------------------------------------------------------------------
  // comparison limit, kept 17 bits wide so the sum never wraps
  // ----------------------------------------------------------------------------
  always_comb begin
    if (threshold_mode_select_q) begin
      limit = {1'b0, threshold_value_q} + {1'b0, baseline_value_q};
    end else begin
      limit = {1'b0, threshold_value_q};
    end
    over_limit = ({1'b0, conv_low_count} > limit);
  end

  // ----------------------------------------------------------------------------
  // configuration bits of the control register
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      ref_cap_select_q           <= 3'b000;
      start_idle_delay_enable_q  <= 1'b0;
      pseudo_random_seq_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      ref_cap_select_q           <= reg_wdata[TSU_CAP_LSB +: 3];
      start_idle_delay_enable_q  <= reg_wdata[TSU_BIT_ASTD];
      pseudo_random_seq_enable_q <= reg_wdata[TSU_BIT_PSRD];
    end
  end

  // ----------------------------------------------------------------------------
  // mode bits (self-scan, threshold mode, baseline init)
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      auto_mode_q             <= 1'b0;
      threshold_mode_select_q <= 1'b0;
      baseline_init_select_q  <= 1'b0;
    end else if (reg_wr && hit(reg_addr, TSU_ADDR_MODE)) begin
      auto_mode_q             <= reg_wdata[TSU_MODE_AUTO];
      threshold_mode_select_q <= reg_wdata[TSU_MODE_THDS];
      baseline_init_select_q  <= reg_wdata[TSU_MODE_BINI];
    end
  end

  // ----------------------------------------------------------------------------
  // conversion sequencer: busy from start until one cycle after the result lands
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q      <= TSU_IDLE;
      conv_busy_q  <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      case (state_q)
        TSU_IDLE: begin
          // a second start while busy is ignored, front end owns the sequence
          if (start_req) begin
            state_q      <= TSU_CONV;
            conv_busy_q  <= 1'b1;
            conv_start_q <= 1'b1;
          end
        end
        TSU_CONV: begin
          if (conv_done) begin
            state_q <= TSU_EVAL;
          end
        end
        TSU_EVAL: begin
          state_q     <= TSU_IDLE;
          conv_busy_q <= 1'b0;
        end
        default: begin
          state_q     <= TSU_IDLE;
          conv_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt flag and wakeup; hardware set beats a same-cycle clear
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      touch_irq_q <= 1'b0;
      wakeup_q    <= 1'b0;
    end else begin
      wakeup_q <= conv_done && auto_mode_q && over_limit;
      if (conv_done && (!auto_mode_q || over_limit)) begin
        touch_irq_q <= 1'b1;
      end else if (irq_clr) begin
        touch_irq_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // low-frequency noise flag
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_freq_noise_flag_q <= 1'b0;
    end else if (conv_noise && conv_busy_q) begin
      low_freq_noise_flag_q <= 1'b1;
    end else if (low_freq_noise_flag_clr) begin
      low_freq_noise_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // duty count results, read-only to software
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      high_duty_count_q <= TSU_RST_WORD;
      low_duty_count_q  <= TSU_RST_WORD;
    end else if (conv_done) begin
      high_duty_count_q <= conv_high_count;
      low_duty_count_q  <= conv_low_count;
    end
  end

  // ----------------------------------------------------------------------------
  // baseline: software bytes, first-count seed, then moving average
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      first_auto_q <= 1'b0;
    end else if (!auto_mode_q) begin
      first_auto_q <= 1'b1; // armed until the first self-scan result
    end else if (conv_done) begin
      first_auto_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      baseline_value_q <= TSU_RST_WORD;
    end else if (auto_mode_q && conv_done && first_auto_q && baseline_init_select_q) begin
      baseline_value_q <= conv_low_count;
    end else if (auto_mode_q && avg_update) begin
      baseline_value_q <= avg_baseline;
    end else if (reg_wr && hit(reg_addr, TSU_ADDR_BASE_LO)) begin
      baseline_value_q[7:0] <= reg_wdata;
    end else if (reg_wr && hit(reg_addr, TSU_ADDR_BASE_HI)) begin
      baseline_value_q[15:8] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // detection threshold
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      threshold_value_q <= TSU_RST_WORD;
    end else if (reg_wr && hit(reg_addr, TSU_ADDR_THD_LO)) begin
      threshold_value_q[7:0] <= reg_wdata;
    end else if (reg_wr && hit(reg_addr, TSU_ADDR_THD_HI)) begin
      threshold_value_q[15:8] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // reference-node pull control
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      dc_current_enable_q  <= 1'b0;
      dc_resistor_enable_q <= 1'b0;
      dc_pull_select_q     <= TSU_PULL_OFF;
    end else if (reg_wr && hit(reg_addr, TSU_ADDR_PULL)) begin
      dc_current_enable_q  <= reg_wdata[TSU_PULL_I_EN];
      dc_resistor_enable_q <= reg_wdata[TSU_PULL_R_EN];
      dc_pull_select_q     <= reg_wdata[TSU_PULL_SEL_W-1:0];
    end
  end

  // leg switches onto the reference node
  tsu_pull_drive u_pull (
    .mclk      (mclk),
    .reset     (reset),
    .cur_en    (dc_current_enable_q),
    .res_en    (dc_resistor_enable_q),
    .pull_sel  (dc_pull_select_q),
    .cur_leg_q (cur_leg_q),
    .res_leg_q (res_leg_q)
  );

  // ----------------------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata_q <= TSU_RST_BYTE;
    end else if (!reg_rd) begin
      reg_rdata_q <= TSU_RST_BYTE; // data stands only in the cycle after the strobe
    end else begin
      case (reg_addr)
        TSU_ADDR_CTRL_STAT: reg_rdata_q <= {ref_cap_select_q, start_idle_delay_enable_q,
                                            pseudo_random_seq_enable_q,
                                            low_freq_noise_flag_q, touch_irq_q,
                                            conv_busy_q};
        TSU_ADDR_HDTY_LO:   reg_rdata_q <= high_duty_count_q[7:0];
        TSU_ADDR_HDTY_HI:   reg_rdata_q <= high_duty_count_q[15:8];
        TSU_ADDR_LDTY_LO:   reg_rdata_q <= low_duty_count_q[7:0];
        TSU_ADDR_LDTY_HI:   reg_rdata_q <= low_duty_count_q[15:8];
        TSU_ADDR_BASE_LO:   reg_rdata_q <= baseline_value_q[7:0];
        TSU_ADDR_BASE_HI:   reg_rdata_q <= baseline_value_q[15:8];
        TSU_ADDR_THD_LO:    reg_rdata_q <= threshold_value_q[7:0];
        TSU_ADDR_THD_HI:    reg_rdata_q <= threshold_value_q[15:8];
        TSU_ADDR_PULL:      reg_rdata_q <= {dc_current_enable_q, dc_resistor_enable_q,
                                            2'b00, dc_pull_select_q};
        TSU_ADDR_MODE:      reg_rdata_q <= {5'b00000, baseline_init_select_q,
                                            threshold_mode_select_q, auto_mode_q};
        default:            reg_rdata_q <= TSU_RST_BYTE;
      endcase
    end
  end

endmodule

// *** tb/tsu_regs_props.sv ***
// tsu_regs_props: concurrent checks on the touch sense unit register ports
// assumes a bind to tsu_regs, one clock domain, sync active-high reset
`timescale 1ns/10ps
module tsu_regs_chk
  import tsu_pkg::*;
(
  input wire logic        mclk,         // system clock
  input wire logic        reset,        // sync reset
  input wire logic [15:0] reg_addr,     // byte address
  input wire logic [7:0]  reg_wdata,    // write data
  input wire logic        reg_wr,       // write strobe
  input wire logic        reg_rd,       // read strobe
  input wire logic [7:0]  reg_rdata_q,  // read data
  input wire logic        conv_done,    // result pulse
  input wire logic        conv_start_q, // start pulse
  input wire logic        conv_busy_q,  // busy level
  input wire logic        auto_mode_q,  // self-scan mode
  input wire logic        wakeup_q,     // wakeup pulse
  input wire logic        touch_irq_q,  // irq flag
  input wire logic [3:0]  cur_leg_q,    // current legs
  input wire logic [3:0]  res_leg_q     // resistor legs
);
  // ---------------------------------------------------------------
  // write decodes
  // ---------------------------------------------------------------
  logic ctl_wr;
  logic pull_wr;
  // plain decodes, kept out of the properties for readability
  assign ctl_wr  = reg_wr && reg_addr == TSU_ADDR_CTRL_STAT;
  assign pull_wr = reg_wr && reg_addr == TSU_ADDR_PULL;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata_q == 8'h00;
  endproperty
  property p_start;
    ctl_wr && reg_wdata[0] && !conv_busy_q |=> conv_start_q && conv_busy_q;
  endproperty
  // a start while busy must not leak out as a second pulse
  property p_start_src;
    conv_start_q |-> $past(ctl_wr && reg_wdata[0] && !conv_busy_q);
  endproperty
  property p_busy_end;
    conv_done && conv_busy_q |-> ##2 !conv_busy_q;
  endproperty
  property p_busy_hold;
    conv_busy_q && !conv_done && !$past(conv_done) |=> conv_busy_q;
  endproperty
  property p_irq_norm;
    conv_done && conv_busy_q && !auto_mode_q |=> touch_irq_q;
  endproperty
  // hardware set wins, so the clear is only owed without a result pulse
  property p_irq_clr;
    ctl_wr && !reg_wdata[1] && !conv_done |=> !touch_irq_q;
  endproperty
  property p_irq_hold;
    touch_irq_q && !(ctl_wr && !reg_wdata[1]) |=> touch_irq_q;
  endproperty
  property p_wake;
    wakeup_q |-> $past(conv_done && auto_mode_q) && touch_irq_q;
  endproperty
  // checked two cycles on, so either leg latency passes if the value held
  property p_pull;
    pull_wr ##1 !pull_wr |=>
      cur_leg_q == ({4{$past(reg_wdata[7], 2)}} & $past(reg_wdata[3:0], 2)) &&
      res_leg_q == ({4{$past(reg_wdata[6], 2)}} & $past(reg_wdata[3:0], 2));
  endproperty
  a_rd_idle:   assert property (p_rd_idle) else $error("read data not zero");
  a_start:     assert property (p_start) else $error("start not launched");
  a_start_src: assert property (p_start_src) else $error("stray start");
  a_busy_end:  assert property (p_busy_end) else $error("busy stuck");
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
  a_irq_norm:  assert property (p_irq_norm) else $error("irq not set");
  a_irq_clr:   assert property (p_irq_clr) else $error("irq not cleared");
  a_irq_hold:  assert property (p_irq_hold) else $error("irq lost");
  a_wake:      assert property (p_wake) else $error("wakeup unexpected");
  a_pull:      assert property (p_pull) else $error("pull legs wrong");
  c_norm:   cover property (conv_done && conv_busy_q && !auto_mode_q);
  c_wake:   cover property (wakeup_q);
  c_refuse: cover property (ctl_wr && reg_wdata[0] && conv_busy_q);
endmodule

bind tsu_regs tsu_regs_chk chk_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .conv_done(conv_done), .conv_start_q(conv_start_q), .conv_busy_q(conv_busy_q),
  .auto_mode_q(auto_mode_q), .wakeup_q(wakeup_q), .touch_irq_q(touch_irq_q),
  .cur_leg_q(cur_leg_q), .res_leg_q(res_leg_q));

// *** tb/testbench.sv ***
// testbench: random, self-checking run of the touch sense unit registers
// assumes tsu_regs alone at its ports, with the checker bound to it
`timescale 1ns/10ps
module testbench;
  import tsu_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        conv_done = 1'b0, conv_noise = 1'b0, avg_update = 1'b0;
  logic [15:0] reg_addr = 16'h0000, hc = 16'h0000, lc = 16'h0000, avg_b = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [4:0]  ctl = 5'h00;
  logic [7:0]  reg_rdata_q;
  logic [2:0]  cap_q;
  logic [3:0]  cur_q, res_q;
  logic        start_q, busy_q, auto_q, wake_q, irq_q, astd_q, psrd_q;
  integer      failures = 0, checks_done = 0, seed = 89;
  logic [15:0] regs [12] = '{TSU_ADDR_CTRL_STAT, TSU_ADDR_HDTY_LO, TSU_ADDR_HDTY_HI,
    TSU_ADDR_LDTY_LO, TSU_ADDR_LDTY_HI, TSU_ADDR_BASE_LO, TSU_ADDR_BASE_HI,
    TSU_ADDR_THD_LO, TSU_ADDR_THD_HI, TSU_ADDR_PULL, TSU_ADDR_MODE, 16'hA020};

  // clock, 5 ns period
  always #2.5 mclk = ~mclk;

  tsu_regs dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .conv_done(conv_done),
    .conv_high_count(hc), .conv_low_count(lc), .conv_noise(conv_noise),
    .avg_update(avg_update), .avg_baseline(avg_b), .conv_start_q(start_q),
    .conv_busy_q(busy_q), .auto_mode_q(auto_q), .wakeup_q(wake_q), .touch_irq_q(irq_q),
    .ref_cap_select_q(cap_q), .start_idle_delay_enable_q(astd_q),
    .pseudo_random_seq_enable_q(psrd_q), .cur_leg_q(cur_q), .res_leg_q(res_q));

  // ---------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------
  function automatic logic [7:0] rw_exp(input logic [15:0] a, input logic [7:0] d);
    case (a)
      TSU_ADDR_BASE_LO, TSU_ADDR_BASE_HI, TSU_ADDR_THD_LO, TSU_ADDR_THD_HI: return d;
      TSU_ADDR_PULL: return d & 8'hCF;
      TSU_ADDR_MODE: return d & 8'h07;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] legs_exp(input logic [7:0] d);
    return {d[7] ? d[3:0] : 4'h0, d[6] ? d[3:0] : 4'h0};
  endfunction
  // operands kept below half range so the sum never wraps
  function automatic logic [15:0] lim_exp(input logic m, input logic [15:0] b, t);
    return m ? b + t : t;
  endfunction

  // ---------------------------------------------------------------
  // bus and conversion tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, 16'(e), 16'(reg_rdata_q));
  endtask
  // flag bits written as one so a start never clears them
  task automatic run_conv(input logic [15:0] h, l, input logic ns, output logic w, q);
    wr(TSU_ADDR_CTRL_STAT, {ctl, 3'b111});
    #1 chk("start", 16'h0003, 16'({start_q, busy_q}));
    wr(TSU_ADDR_CTRL_STAT, {ctl, 3'b111});
    #1 chk("start while busy", 16'h0000, 16'(start_q));
    @(posedge mclk);
    conv_noise <= ns;
    @(posedge mclk);
    conv_noise <= 1'b0;
    conv_done <= 1'b1;
    hc <= h;
    lc <= l;
    @(posedge mclk);
    conv_done <= 1'b0;
    #1 w = wake_q;
    q = irq_q;
    repeat (2) @(posedge mclk);
    #1 chk("busy end", 16'h0000, 16'(busy_q));
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  d;
    logic [15:0] b, t, v, x;
    logic        w, q;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    foreach (regs[i]) rchk("reset value", regs[i], 8'h00);
    for (int i = 1; i < 12; i++) begin
      d = 8'($random(seed));
      wr(regs[i], d);
      rchk("write back", regs[i], rw_exp(regs[i], d));
    end
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      d[7:6] = 2'(k);
      wr(TSU_ADDR_PULL, d);
      repeat (2) @(posedge mclk);
      #1 chk("pull legs", 16'(legs_exp(d)), 16'({cur_q, res_q}));
    end
    wr(TSU_ADDR_MODE, 8'h00);
    ctl = 5'($random(seed));
    x = 16'($random(seed));
    v = 16'($random(seed));
    run_conv(x, v, 1'b1, w, q);
    chk("normal irq", 16'h0001, 16'(q));
    chk("ctl outs", 16'(ctl), 16'({cap_q, astd_q, psrd_q}));
    rchk("status", TSU_ADDR_CTRL_STAT, {ctl, 3'b110});
    rchk("high lo", TSU_ADDR_HDTY_LO, x[7:0]);
    rchk("high hi", TSU_ADDR_HDTY_HI, x[15:8]);
    rchk("low lo", TSU_ADDR_LDTY_LO, v[7:0]);
    rchk("low hi", TSU_ADDR_LDTY_HI, v[15:8]);
    wr(TSU_ADDR_CTRL_STAT, {ctl, 3'b000});
    rchk("flags clear", TSU_ADDR_CTRL_STAT, {ctl, 3'b000});
    for (int m = 0; m < 2; m++) begin
      b = 16'($random(seed)) & 16'h7FFF;
      t = 16'($random(seed)) & 16'h7FFF;
      wr(TSU_ADDR_MODE, 8'h00);
      wr(TSU_ADDR_BASE_LO, b[7:0]);
      wr(TSU_ADDR_BASE_HI, b[15:8]);
      wr(TSU_ADDR_THD_LO, t[7:0]);
      wr(TSU_ADDR_THD_HI, t[15:8]);
      wr(TSU_ADDR_MODE, {6'h00, 1'(m), 1'b1});
      for (int ov = 0; ov < 2; ov++) begin
        run_conv(x, lim_exp(1'(m), b, t) + 16'(1 - ov), 1'b0, w, q);
        chk("wakeup irq", 16'({2{ov == 0}}), 16'({w, q}));
        wr(TSU_ADDR_CTRL_STAT, {ctl, 3'b000});
      end
      v = 16'($random(seed));
      @(posedge mclk);
      avg_update <= 1'b1;
      avg_b <= v;
      @(posedge mclk);
      avg_update <= 1'b0;
      rchk("avg lo", TSU_ADDR_BASE_LO, v[7:0]);
      rchk("avg hi", TSU_ADDR_BASE_HI, v[15:8]);
    end
    wr(TSU_ADDR_MODE, 8'h00);
    wr(TSU_ADDR_MODE, 8'h05);
    for (int j = 0; j < 2; j++) begin
      x = 16'($random(seed));
      if (j == 0) v = x;
      run_conv(16'h0000, x, 1'b0, w, q);
      rchk("seed lo", TSU_ADDR_BASE_LO, v[7:0]);
      rchk("seed hi", TSU_ADDR_BASE_HI, v[15:8]);
    end
    tally_and_finish;
  end

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    tally_and_finish;
  end
endmodule
